/* File: dts_pkg.sv */
package dts_pkg;
    // debug observation bus slice owned by this block
    localparam int DBG_LO = 280;
    localparam int DBG_HI = 295;
    localparam int DBG_W = DBG_HI - DBG_LO + 1;
    localparam int STATE_LSB = 280 - DBG_LO;
    localparam int TLPSENT_BIT = 283 - DBG_LO;
    localparam int DLLPSENT_BIT = 284 - DBG_LO;
    localparam int GNT_LSB = 285 - DBG_LO;
    localparam int BEGIN_BIT = 293 - DBG_LO;
    localparam int FINISH_BIT = 294 - DBG_LO;
    localparam int EOT_BIT = 295 - DBG_LO;
    // grant bit positions
    localparam int GNT_W = 8;
    localparam int G_INITFC = 0;
    localparam int G_ACKHI = 1;
    localparam int G_UFCHI = 2;
    localparam int G_PM = 3;
    localparam int G_NEW = 4;
    localparam int G_REPLAY = 5;
    localparam int G_UFCLO = 6;
    localparam int G_ACKLO = 7;
    // transmit state codes
    localparam logic [2:0] ST_IDLE = 3'h0;
    localparam logic [2:0] ST_FIRST = 3'h1;
    localparam logic [2:0] ST_SECOND = 3'h2;
    localparam logic [2:0] ST_THIRD = 3'h3;
    localparam logic [2:0] ST_ECRC1 = 3'h4;
    localparam logic [2:0] ST_ECRC2 = 3'h5;
    localparam logic [2:0] ST_RSVD = 3'h7;
    localparam int LEN_W = 10;
    // AXI4-Lite register map
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STATUS = 8'h04;
    localparam logic [7:0] A_GRANT = 8'h08;
    localparam logic [7:0] A_TLPCNT = 8'h0C;
    localparam logic [7:0] A_DLLPCNT = 8'h10;
    localparam logic [31:0] CTRL_RST = 32'h0000_0001;
    localparam int CTRL_EN = 0;
    localparam int CTRL_ECRC = 1;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [2:0] {S_IDLE, S_FIRST, S_SECOND, S_THIRD, S_ECRC1, S_ECRC2} dts_state_t;
endpackage : dts_pkg

/* File: dts_arbiter.sv */
`timescale 1ns/10ps
`default_nettype none
module dts_arbiter (
    input wire logic [dts_pkg::GNT_W-1:0] req,
    input wire logic enable,
    output logic [dts_pkg::GNT_W-1:0] gnt
);
    import dts_pkg::*;
    // fixed priority by grant index: lowest index wins, so only one bit ever rises
    logic [GNT_W-1:0] lower;
    assign lower[0] = 1'b0;
    genvar i;
    generate
        for (i = 1; i < GNT_W; i++) begin : g_chain
            assign lower[i] = lower[i-1] | req[i-1];
        end
    endgenerate
    assign gnt = enable ? (req & ~lower) : '0; // R13
endmodule : dts_arbiter
`default_nettype wire

/* File: dts_scheduler.sv */
// Function
// [R1] tx state code on debug 282:280
// [R2] ecrc states only when ecrc appended
// [R3] tlp-sent flag on final lcrc dword
// [R4] test logic may time crc corruption
// [R5] dllp-sent flag when dllp handed over
// [R6] dllp/tlp arbitration reported on grant field
// [R7] grant bits for each dllp kind
// [R8] new tlp bit 4, replay bit 5
// [R9] packet-begin while start symbol passes
// [R10] packet-finish while end symbol passes
// [R11] begin plus finish means dllp
// [R12] end-of-transmit after previous transmission completes
// [R13] at most one grant per cycle
`timescale 1ns/10ps
`default_nettype none
module dts_scheduler (
    input wire logic clk,
    input wire logic rst,
    // pending requests, one per grant index
    input wire logic [dts_pkg::GNT_W-1:0] txReq,
    input wire logic [dts_pkg::LEN_W-1:0] newTlpDw,
    input wire logic [dts_pkg::LEN_W-1:0] replayTlpDw,
    input wire logic newTlpEcrc,
    input wire logic phyReady,
    output logic [dts_pkg::GNT_W-1:0] txGrant,
    output logic phySop,
    output logic phyEop,
    output logic phyValid,
    output logic phyIsDllp,
    output logic [dts_pkg::DBG_W-1:0] debugOut,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import dts_pkg::*;

    dts_state_t state_r, state_nxt;
    logic [LEN_W-1:0] dwLeft_r;
    logic ecrc_r;
    logic [GNT_W-1:0] gntHold_r;
    logic [31:0] ctrl_r;
    logic [31:0] tlpCnt_r;
    logic [31:0] dllpCnt_r;
    logic sop_r, eop_r, valid_r, isDllp_r, tlpSent_r, dllpSent_r, eot_r;
    logic [GNT_W-1:0] gnt_r;

    function automatic logic [2:0] stateCode(input dts_state_t s);
        case (s)
            S_IDLE: stateCode = ST_IDLE;
            S_FIRST: stateCode = ST_FIRST;
            S_SECOND: stateCode = ST_SECOND;
            S_THIRD: stateCode = ST_THIRD;
            S_ECRC1: stateCode = ST_ECRC1;
            S_ECRC2: stateCode = ST_ECRC2;
            default: stateCode = ST_RSVD;
        endcase
    endfunction : stateCode

    // arbitration only when the path is free and the phy can take a symbol
    wire logic pathFree = (state_r == S_IDLE) && phyReady;
    wire logic [GNT_W-1:0] arbGnt;
    dts_arbiter u_arb (
        .req(txReq),
        .enable(pathFree && ctrl_r[CTRL_EN]),
        .gnt(arbGnt)
    );
    wire logic grantNew = arbGnt[G_NEW];
    wire logic grantReplay = arbGnt[G_REPLAY];
    wire logic grantTlp = grantNew | grantReplay;
    wire logic grantDllp = (|arbGnt) & ~grantTlp;
    // a length of zero is treated as one: first and second dwords, then at least one dword in the third state
    wire logic [LEN_W-1:0] pickLen = grantNew ? newTlpDw : replayTlpDw;
    // only fresh packets can have ecrc appended here; replays carry theirs inside the stored data
    wire logic pickEcrc = grantNew & newTlpEcrc & ctrl_r[CTRL_ECRC];
    wire logic lastBody = (dwLeft_r <= LEN_W'(1));
    wire logic lastDw = phyReady && ((state_r == S_THIRD && !ecrc_r && lastBody) || state_r == S_ECRC2);

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            S_IDLE: if (grantTlp) begin
                state_nxt = S_FIRST;
            end
            S_FIRST: if (phyReady) begin
                state_nxt = S_SECOND;
            end
            S_SECOND: if (phyReady) begin
                state_nxt = S_THIRD;
            end
            S_THIRD: if (phyReady && lastBody) begin
                state_nxt = ecrc_r ? S_ECRC1 : S_IDLE; // R2
            end
            S_ECRC1: if (phyReady) begin
                state_nxt = S_ECRC2; // R2
            end
            S_ECRC2: if (phyReady) begin
                state_nxt = S_IDLE;
            end
            default: state_nxt = S_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r <= S_IDLE;
            dwLeft_r <= '0;
            ecrc_r <= 1'b0;
            gntHold_r <= '0;
        end else begin
            state_r <= state_nxt;
            if (grantTlp) begin
                dwLeft_r <= pickLen;
                ecrc_r <= pickEcrc;
                gntHold_r <= arbGnt;
            end else if (state_r == S_THIRD && phyReady && !lastBody) begin
                dwLeft_r <= dwLeft_r - LEN_W'(1);
            end
            if (state_nxt == S_IDLE && state_r != S_IDLE) begin
                gntHold_r <= '0;
            end
        end
    end

    // framing and debug flags, all registered
    always_ff @(posedge clk) begin
        if (rst) begin
            sop_r <= 1'b0;
            eop_r <= 1'b0;
            valid_r <= 1'b0;
            isDllp_r <= 1'b0;
            tlpSent_r <= 1'b0;
            dllpSent_r <= 1'b0;
            eot_r <= 1'b1;
            gnt_r <= '0;
        end else begin
            sop_r <= grantDllp | grantTlp; // R9
            eop_r <= grantDllp | lastDw; // R10 R11
            valid_r <= grantDllp | grantTlp | (state_r != S_IDLE && phyReady);
            isDllp_r <= grantDllp; // R11
            tlpSent_r <= lastDw; // R3
            dllpSent_r <= grantDllp; // R5
            gnt_r <= arbGnt | gntHold_r; // R6 R7 R8
            // idle, nothing granted and the last symbol already gone
            // wait for the cycle after the end symbol, so eot never overlaps a packet still on its grant
            eot_r <= (state_r == S_IDLE) && !grantDllp && !grantTlp; // R12
        end
    end

    assign txGrant = gnt_r;
    assign phySop = sop_r;
    assign phyEop = eop_r;
    assign phyValid = valid_r;
    assign phyIsDllp = isDllp_r;

    // observation slice; the state code trails the fsm by one cycle to line up with flags
    logic [2:0] stCode_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            stCode_r <= ST_IDLE;
        end else begin
            stCode_r <= stateCode(state_r); // R1 R4
        end
    end
    always_comb begin
        debugOut = '0;
        debugOut[STATE_LSB +: 3] = stCode_r; // R1
        debugOut[TLPSENT_BIT] = tlpSent_r; // R3
        debugOut[DLLPSENT_BIT] = dllpSent_r; // R5
        debugOut[GNT_LSB +: GNT_W] = gnt_r; // R6
        debugOut[BEGIN_BIT] = sop_r; // R9
        debugOut[FINISH_BIT] = eop_r; // R10
        debugOut[EOT_BIT] = eot_r; // R12
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            tlpCnt_r <= '0;
            dllpCnt_r <= '0;
        end else begin
            if (lastDw) begin
                tlpCnt_r <= tlpCnt_r + 32'h0000_0001;
            end
            if (grantDllp) begin
                dllpCnt_r <= dllpCnt_r + 32'h0000_0001;
            end
        end
    end

    // AXI4-Lite: address and data taken in either order, response after both
    logic awHave_r, wHave_r, bValid_r, rValid_r;
    logic [7:0] awAddr_r, arAddr_r;
    logic [31:0] wData_r, rData_r;
    logic [3:0] wStrb_r;
    logic [1:0] bResp_r, rResp_r;
    assign s_axi_awready = !awHave_r && !bValid_r;
    assign s_axi_wready = !wHave_r && !bValid_r;
    assign s_axi_arready = !rValid_r;
    assign s_axi_bvalid = bValid_r;
    assign s_axi_bresp = bResp_r;
    assign s_axi_rvalid = rValid_r;
    assign s_axi_rdata = rData_r;
    assign s_axi_rresp = rResp_r;

    wire logic doWrite = awHave_r && wHave_r && !bValid_r;
    wire logic wrCtrl = doWrite && (awAddr_r == A_CTRL);
    wire logic [31:0] strobeMask = {{8{wStrb_r[3]}}, {8{wStrb_r[2]}}, {8{wStrb_r[1]}}, {8{wStrb_r[0]}}};
    wire logic [31:0] ctrlMerged = (ctrl_r & ~strobeMask) | (wData_r & strobeMask);
    wire logic wrMapped = (awAddr_r == A_CTRL);
    wire logic [7:0] rdAddr = s_axi_araddr;
    wire logic rdMapped = (rdAddr == A_CTRL) || (rdAddr == A_STATUS) || (rdAddr == A_GRANT)
                       || (rdAddr == A_TLPCNT) || (rdAddr == A_DLLPCNT);
    wire logic [31:0] statusWord = {16'h0000, debugOut};
    wire logic [31:0] rdMux = (rdAddr == A_CTRL) ? ctrl_r :
                              (rdAddr == A_STATUS) ? statusWord :
                              (rdAddr == A_GRANT) ? {24'h000000, gnt_r} :
                              (rdAddr == A_TLPCNT) ? tlpCnt_r :
                              (rdAddr == A_DLLPCNT) ? dllpCnt_r : 32'h0000_0000;

    always_ff @(posedge clk) begin
        if (rst) begin
            awHave_r <= 1'b0;
            wHave_r <= 1'b0;
            bValid_r <= 1'b0;
            awAddr_r <= '0;
            wData_r <= '0;
            wStrb_r <= '0;
            bResp_r <= RESP_OKAY;
            ctrl_r <= CTRL_RST;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHave_r <= 1'b1;
                awAddr_r <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHave_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
            if (doWrite) begin
                awHave_r <= 1'b0;
                wHave_r <= 1'b0;
                bValid_r <= 1'b1;
                bResp_r <= wrMapped ? RESP_OKAY : RESP_SLVERR;
            end else if (bValid_r && s_axi_bready) begin
                bValid_r <= 1'b0;
            end
            if (wrCtrl) begin
                ctrl_r <= ctrlMerged & 32'h0000_0003;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rValid_r <= 1'b0;
            rData_r <= '0;
            rResp_r <= RESP_OKAY;
            arAddr_r <= '0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rValid_r <= 1'b1;
            arAddr_r <= rdAddr;
            rData_r <= rdMux;
            rResp_r <= rdMapped ? RESP_OKAY : RESP_SLVERR;
        end else if (rValid_r && s_axi_rready) begin
            rValid_r <= 1'b0;
        end
    end
endmodule : dts_scheduler
`default_nettype wire

/* File: dts_scheduler_asserts.sv */
`timescale 1ns/10ps
`default_nettype none
module dts_scheduler_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic [dts_pkg::GNT_W-1:0] txGrant,
    input wire logic phySop,
    input wire logic phyEop,
    input wire logic phyIsDllp,
    input wire logic [dts_pkg::DBG_W-1:0] debugOut
);
    import dts_pkg::*;
    logic tlpG;
    assign tlpG = txGrant[G_NEW] || txGrant[G_REPLAY];
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_one_grant: assert property ($onehot0(txGrant)) else $error("grant not one-hot");
    a_state_code: assert property (debugOut[2:0] != 3'h6 && debugOut[2:0] != ST_RSVD) else $error("bad state");
    a_grant_mirror: assert property (debugOut[GNT_LSB+:GNT_W] == txGrant) else $error("grant field");
    a_dllp_frame: assert property (|txGrant && !tlpG |-> phySop && phyEop && phyIsDllp) else $error("dllp frame");
    a_dllp_flag: assert property (debugOut[DLLPSENT_BIT] == (phySop && phyEop)) else $error("dllp flag");
    a_begin_finish: assert property (debugOut[BEGIN_BIT] == phySop && debugOut[FINISH_BIT] == phyEop)
        else $error("begin or finish");
    a_tlp_sent: assert property (debugOut[TLPSENT_BIT] |-> phyEop && !phySop && tlpG) else $error("tlp flag");
    a_tlp_open: assert property ($rose(tlpG) |-> phySop && !phyEop ##1 tlpG) else $error("tlp start");
    a_eot_idle: assert property (debugOut[EOT_BIT] |-> txGrant == 8'h00) else $error("eot while granted");
    c_dllp: cover property (phySop && phyEop);
    c_ecrc: cover property (debugOut[2:0] == ST_ECRC2);
    c_replay: cover property (txGrant[G_REPLAY]);
endmodule : dts_scheduler_asserts
bind dts_scheduler dts_scheduler_asserts u_chk (.clk(clk), .rst(rst), .txGrant(txGrant), .phySop(phySop),
    .phyEop(phyEop), .phyIsDllp(phyIsDllp), .debugOut(debugOut));
`default_nettype wire

/* File: dts_phy_model.sv */
`timescale 1ns/10ps
`default_nettype none
module dts_phy_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic slow,
    input wire logic phyValid,
    input wire logic phySop,
    input wire logic phyEop,
    output logic phyReady,
    output int dllpSeen,
    output int tlpSeen
);
    logic [3:0] pace_r;
    // pseudo-random refusals so stalls land on every framing phase
    assign phyReady = !slow || pace_r[0];
    always_ff @(posedge clk) begin
        if (rst) begin
            pace_r <= 4'h9;
            dllpSeen <= 0;
            tlpSeen <= 0;
        end else begin
            pace_r <= {pace_r[2:0], pace_r[3] ^ pace_r[2]};
            // framing outputs show a symbol already taken at the grant edge, so ready is not looked at here
            if (phyValid && phySop && phyEop) dllpSeen <= dllpSeen + 1;
            if (phyValid && phySop && !phyEop) tlpSeen <= tlpSeen + 1;
        end
    end
endmodule : dts_phy_model
`default_nettype wire

/* File: dll_transmit_scheduler_test.sv */
`timescale 1ns/10ps
`default_nettype none
module dll_transmit_scheduler_test;
    import dts_pkg::*;
    logic clk = 0, rst = 1, slow = 0, newTlpEcrc = 0;
    logic [GNT_W-1:0] txReq = '0, txGrant;
    logic [LEN_W-1:0] newTlpDw = '0, replayTlpDw = '0;
    logic phyReady, phySop, phyEop, phyValid, phyIsDllp;
    logic [DBG_W-1:0] debugOut;
    logic [7:0] awaddr = '0, araddr = '0, lfsr = 8'h04;
    logic [31:0] wdata = '0, rdata, d;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [2:0] sentSt;
    logic [7:0] kinds [$] = '{8'h01, 8'h02, 8'h04, 8'h08, 8'h40, 8'h80};
    int error_cnt = 0, compares = 0, expDllp = 0, expTlp = 0, thirds, ecrcs, dllpSeen, tlpSeen;
    always #4 clk = ~clk;
    dts_scheduler DUT (.clk(clk), .rst(rst), .txReq(txReq), .newTlpDw(newTlpDw), .replayTlpDw(replayTlpDw),
        .newTlpEcrc(newTlpEcrc), .phyReady(phyReady), .txGrant(txGrant), .phySop(phySop), .phyEop(phyEop),
        .phyValid(phyValid), .phyIsDllp(phyIsDllp), .debugOut(debugOut), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    dts_phy_model u_phy (.clk(clk), .rst(rst), .slow(slow), .phyValid(phyValid), .phySop(phySop),
        .phyEop(phyEop), .phyReady(phyReady), .dllpSeen(dllpSeen), .tlpSeen(tlpSeen));
    function automatic logic [7:0] nextRnd(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : nextRnd
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out();
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : close_out
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] r);
        logic aw, w;
        aw = 1;
        w = 1;
        awaddr <= a;
        wdata <= v;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (aw || w) begin
            @(posedge clk);
            aw = aw && !awready;
            w = w && !wready;
            awvalid <= aw;
            wvalid <= w;
        end
        while (!bvalid) @(posedge clk);
        check(bresp, r);
        bready <= 0;
        @(posedge clk);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a, input logic [1:0] r);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        @(posedge clk);
        while (!arready) @(posedge clk);
        arvalid <= 0;
        while (!rvalid) @(posedge clk);
        d = rdata;
        check(rresp, r);
        rready <= 0;
        @(posedge clk);
    endtask : axi_rd
    // requests are dropped just after the grant shows, before the next take edge
    task automatic serve(input logic [7:0] m);
        logic [7:0] low;
        txReq <= txReq | m;
        @(posedge clk);
        #1;
        while (m != 0) begin
            low = m & (~m + 8'h01);
            if (txGrant != 8'h00) begin
                check(txGrant, low);
                m = m & ~low;
                txReq <= m;
                if (low & 8'h30) expTlp++;
                else expDllp++;
                while (txGrant === low) begin
                    @(posedge clk);
                    #1;
                end
            end else begin
                @(posedge clk);
                #1;
            end
        end
    endtask : serve
    always @(posedge clk) begin
        if (debugOut[2:0] === ST_THIRD) thirds++;
        if (debugOut[2:0] === ST_ECRC1 || debugOut[2:0] === ST_ECRC2) ecrcs++;
        if (debugOut[TLPSENT_BIT] === 1'b1) sentSt = debugOut[2:0];
    end
    task automatic tlp(input logic [7:0] m, input logic [31:0] th, input logic [31:0] ec);
        thirds = 0;
        ecrcs = 0;
        serve(m);
        repeat (3) @(posedge clk);
        check(thirds, th);
        check(ecrcs, ec);
        check(sentSt, ec != 0 ? ST_ECRC2 : ST_THIRD);
    endtask : tlp
    initial begin
        repeat (12) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        check(debugOut[EOT_BIT], 1'b1);
        check(debugOut[2:0], ST_IDLE);
        axi_rd(A_CTRL, RESP_OKAY);
        check(d, CTRL_RST);
        axi_rd(8'h20, RESP_SLVERR);
        check(d, 32'h0);
        axi_wr(A_STATUS, 32'h0, RESP_SLVERR);
        $display("registers done");
        slow <= 1;
        foreach (kinds[i]) serve(kinds[i]);
        serve(8'hCE);
        $display("dllp kinds done");
        slow <= 0;
        axi_wr(A_CTRL, 32'h3, RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            lfsr = nextRnd(lfsr);
            newTlpDw <= {7'h00, lfsr[2:0]};
            newTlpEcrc <= i[0];
            if (i == 2) axi_wr(A_CTRL, 32'h1, RESP_OKAY);
            @(posedge clk);
            tlp(8'h10, lfsr[2:0] == 0 ? 1 : lfsr[2:0], i == 1 ? 2 : 0);
        end
        lfsr = nextRnd(lfsr);
        replayTlpDw <= {7'h00, lfsr[2:0]};
        newTlpDw <= 10'h000;
        newTlpEcrc <= 0;
        tlp(8'h31, 1 + (lfsr[2:0] == 0 ? 1 : lfsr[2:0]), 0);
        $display("tlp done");
        axi_wr(A_CTRL, 32'h0, RESP_OKAY);
        txReq <= 8'h40;
        repeat (10) @(posedge clk);
        check(txGrant, 8'h00);
        // drop the held request so re-enabling does not grant it on every idle cycle
        txReq <= 8'h00;
        axi_wr(A_CTRL, 32'h1, RESP_OKAY);
        serve(8'h40);
        axi_rd(A_TLPCNT, RESP_OKAY);
        check(d, expTlp);
        axi_rd(A_DLLPCNT, RESP_OKAY);
        check(d, expDllp);
        axi_rd(A_GRANT, RESP_OKAY);
        check(d, 32'h0000_0000);
        axi_rd(A_STATUS, RESP_OKAY);
        check(d, 32'h0000_0001 << EOT_BIT);
        check(tlpSeen, expTlp);
        check(dllpSeen, expDllp);
        check(debugOut[EOT_BIT], 1'b1);
        $display("disable and counts done");
        close_out();
    end
    initial begin
        #400000;
        error_cnt++;
        close_out();
    end
endmodule : dll_transmit_scheduler_test
`default_nettype wire
